// ==== bli_consts.vh ====
// constants for the boot loader invoke logic
`ifndef BLI_CONSTS_VH
`define BLI_CONSTS_VH

`define BLI_ADDR_W          4
`define BLI_DATA_W          32
`define BLI_PW_WORDS        8
`define BLI_PW_BITS         256

// word index; byte address is four times the index
`define BLI_REG_CONFIG      4'h0
`define BLI_REG_COMMAND     4'h1
`define BLI_REG_STATUS      4'h2
`define BLI_REG_VECTOR      4'h3
`define BLI_REG_PW_FIRST    4'h8

// config fields
`define BLI_CFG_LOADER_EN   0
`define BLI_CFG_FAST_BOOT   1
`define BLI_CFG_INVOKE_LVL  2
`define BLI_CFG_RESET       3'h5

// command fields, write only
`define BLI_CMD_SYSTEM_RESET_LDR  0
`define BLI_CMD_SYSTEM_RESET      1

// status fields
`define BLI_ST_LOADER       0
`define BLI_ST_APP          1
`define BLI_ST_UNLOCKED     2
`define BLI_ST_BOOTING      3
`define BLI_ST_BLANK        4
`define BLI_ST_PW_FAIL      5
`define BLI_ST_CAUSE_LSB    8

// entry causes
`define BLI_CAUSE_NONE      2'h0
`define BLI_CAUSE_PIN       2'h1
`define BLI_CAUSE_BLANK     2'h2
`define BLI_CAUSE_SOFT      2'h3

// an unprogrammed flash word reads all ones
`define BLI_BLANK_WORD      32'hffffffff

`endif

// ==== bli_pw_check.v ====
// password store and compare for the serial boot loader
`timescale 1ns/1ps
`default_nettype none
`include "bli_consts.vh"

module bli_pw_check (
    input  wire                      i_clk_sys,
    input  wire                      i_rst_n,
    input  wire                      i_clear,
    input  wire                      i_wr,
    input  wire [2:0]                i_idx,
    input  wire [`BLI_DATA_W-1:0]    i_word,
    input  wire [`BLI_PW_BITS-1:0]   i_secret,
    output reg                       o_unlocked,
    output reg                       o_fail
);

    reg  [`BLI_DATA_W-1:0]  pw_q [0:`BLI_PW_WORDS-1];
    reg                     check_q;
    reg  [`BLI_PW_BITS-1:0] cat;
    integer                 k;
    integer                 j;

    always @* begin
        cat = {`BLI_PW_BITS{1'b0}};
        for (k = 0; k < `BLI_PW_WORDS; k = k + 1) begin
            cat[k*`BLI_DATA_W +: `BLI_DATA_W] = pw_q[k];
        end
    end

    // writing the last word arms one compare on the next edge
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (j = 0; j < `BLI_PW_WORDS; j = j + 1) begin
                pw_q[j] <= {`BLI_DATA_W{1'b0}};
            end
            check_q    <= 1'b0;
            o_unlocked <= 1'b0;
            o_fail     <= 1'b0;
        end else if (i_clear) begin
            for (j = 0; j < `BLI_PW_WORDS; j = j + 1) begin
                pw_q[j] <= {`BLI_DATA_W{1'b0}};
            end
            check_q    <= 1'b0;
            o_unlocked <= 1'b0;
            o_fail     <= 1'b0;
        end else begin
            if (i_wr) begin
                pw_q[i_idx] <= i_word;
            end
            check_q <= i_wr && (i_idx == 3'h7);
            if (check_q) begin
                o_unlocked <= (cat == i_secret);
                o_fail     <= (cat != i_secret);
            end
        end
    end

endmodule
`default_nettype wire

// ==== bli_link_gate.v ====
// gates loader uart and i2c pins onto the loader core while it runs
`timescale 1ns/1ps
`default_nettype none

module bli_link_gate (
    input  wire i_clk_sys,
    input  wire i_rst_n,
    input  wire i_enable,
    input  wire i_loader_uart_rx,
    output reg  o_loader_uart_tx,
    input  wire i_loader_i2c_clock,
    output reg  o_loader_i2c_clock_out,
    output reg  o_loader_i2c_clock_oe,
    input  wire i_loader_i2c_data,
    output reg  o_loader_i2c_data_out,
    output reg  o_loader_i2c_data_oe,
    input  wire i_core_tx,
    input  wire i_core_i2c_clock_low,
    input  wire i_core_i2c_data_low,
    output reg  o_core_rx,
    output reg  o_core_i2c_clock,
    output reg  o_core_i2c_data
);

    // open drain: only ever drives low; idle lines stay released
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_loader_uart_tx       <= 1'b1;
            o_loader_i2c_clock_out <= 1'b0;
            o_loader_i2c_clock_oe  <= 1'b0;
            o_loader_i2c_data_out  <= 1'b0;
            o_loader_i2c_data_oe   <= 1'b0;
            o_core_rx              <= 1'b1;
            o_core_i2c_clock       <= 1'b1;
            o_core_i2c_data        <= 1'b1;
        end else begin
            o_loader_uart_tx       <= i_enable ? i_core_tx : 1'b1;
            o_loader_i2c_clock_out <= 1'b0;
            o_loader_i2c_clock_oe  <= i_enable && i_core_i2c_clock_low;
            o_loader_i2c_data_out  <= 1'b0;
            o_loader_i2c_data_oe   <= i_enable && i_core_i2c_data_low;
            o_core_rx              <= i_enable ? i_loader_uart_rx : 1'b1;
            o_core_i2c_clock       <= i_enable ? i_loader_i2c_clock : 1'b1;
            o_core_i2c_data        <= i_enable ? i_loader_i2c_data : 1'b1;
        end
    end

endmodule
`default_nettype wire

// ==== bli_invoke.v ====
// boot-time and runtime entry decision for the serial boot loader
`timescale 1ns/1ps
`default_nettype none
`include "bli_consts.vh"

module bli_invoke (
    input  wire                     i_clk_sys,
    input  wire                     i_rst_n,
    // avalon-mm slave
    input  wire [`BLI_ADDR_W-1:0]   i_avs_address,
    input  wire                     i_avs_read,
    input  wire                     i_avs_write,
    input  wire [`BLI_DATA_W-1:0]   i_avs_writedata,
    output reg  [`BLI_DATA_W-1:0]   o_avs_readdata,
    output reg                      o_avs_waitrequest,
    // boot inputs
    input  wire                     i_external_reset_n,
    input  wire                     i_loader_request_pin,
    input  wire [`BLI_DATA_W-1:0]   i_reset_vector,
    input  wire [`BLI_DATA_W-1:0]   i_stack_pointer,
    input  wire [`BLI_PW_BITS-1:0]  i_user_password,
    // boot results
    output reg                      o_loader_start,
    output reg                      o_loader_active,
    output reg                      o_app_start,
    output reg  [`BLI_DATA_W-1:0]   o_app_vector,
    output wire                     o_loader_access_granted,
    // loader link pins
    input  wire                     i_loader_uart_rx,
    output wire                     o_loader_uart_tx,
    input  wire                     i_loader_i2c_clock,
    output wire                     o_loader_i2c_clock_out,
    output wire                     o_loader_i2c_clock_oe,
    input  wire                     i_loader_i2c_data,
    output wire                     o_loader_i2c_data_out,
    output wire                     o_loader_i2c_data_oe,
    // loader core side
    input  wire                     i_core_tx,
    input  wire                     i_core_i2c_clock_low,
    input  wire                     i_core_i2c_data_low,
    output wire                     o_core_rx,
    output wire                     o_core_i2c_clock,
    output wire                     o_core_i2c_data
);

    // hold waits out an external reset; boot samples the pins once
    localparam [2:0] ST_HOLD   = 3'h0;
    localparam [2:0] ST_BOOT   = 3'h1;
    localparam [2:0] ST_DECIDE = 3'h2;
    localparam [2:0] ST_LOADER = 3'h3;
    localparam [2:0] ST_APP    = 3'h4;

    reg  [2:0]              state_q;
    reg  [2:0]              state_d;
    reg  [2:0]              cfg_q;
    reg                     soft_entry_q;
    reg                     soft_reset_q;
    reg  [1:0]              cause_q;
    reg  [1:0]              cause_d;
    reg                     pin_q;
    reg                     blank_q;
    reg                     unlock_clear;
    reg  [`BLI_DATA_W-1:0]  rdata;
    wire                    req;
    wire                    take;
    wire                    wr_take;
    wire                    pw_wr;
    wire                    unlocked;
    wire                    pw_fail;
    wire                    in_loader;

    function blank_word;
        input [`BLI_DATA_W-1:0] w;
        begin
            blank_word = (w == `BLI_BLANK_WORD);
        end
    endfunction

    // register index decode, shared by the config and command write paths
    function reg_hit;
        input [`BLI_ADDR_W-1:0] a;
        input [`BLI_ADDR_W-1:0] idx;
        begin
            reg_hit = (a == idx);
        end
    endfunction

    // bus: waitrequest drops for exactly one cycle per request
    assign req     = i_avs_read || i_avs_write;
    assign take    = req && !o_avs_waitrequest;
    assign wr_take = take && i_avs_write;
    assign pw_wr   = wr_take && (i_avs_address[3] == 1'b1);
    assign in_loader = (state_q == ST_LOADER);

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= {`BLI_DATA_W{1'b0}};
        end else begin
            o_avs_waitrequest <= !(req && o_avs_waitrequest);
            // loaded in the wait cycle so it stands when waitrequest drops
            if (i_avs_read && o_avs_waitrequest) begin
                o_avs_readdata <= rdata;
            end
        end
    end

    // unmapped and write-only indexes read as zero
    always @* begin
        rdata = {`BLI_DATA_W{1'b0}};
        case (i_avs_address)
            `BLI_REG_CONFIG: begin
                rdata[2:0] = cfg_q;
            end
            `BLI_REG_STATUS: begin
                rdata[`BLI_ST_LOADER]   = in_loader;
                rdata[`BLI_ST_APP]      = (state_q == ST_APP);
                rdata[`BLI_ST_UNLOCKED] = unlocked;
                rdata[`BLI_ST_BOOTING]  = !in_loader && (state_q != ST_APP);
                rdata[`BLI_ST_BLANK]    = blank_q;
                rdata[`BLI_ST_PW_FAIL]  = pw_fail;
                rdata[`BLI_ST_CAUSE_LSB +: 2] = cause_q;
            end
            `BLI_REG_VECTOR: begin
                rdata = o_app_vector;
            end
            default: begin
                rdata = {`BLI_DATA_W{1'b0}};
            end
        endcase
    end

    // configuration survives boot resets; only power-on reset restores it
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= `BLI_CFG_RESET;
        end else if (wr_take && reg_hit(i_avs_address, `BLI_REG_CONFIG)) begin
            cfg_q <= i_avs_writedata[2:0];
        end
    end

    // a system reset to loader request is remembered across the restart
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            soft_entry_q <= 1'b0;
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= wr_take &&
                            reg_hit(i_avs_address, `BLI_REG_COMMAND) &&
                            (i_avs_writedata[`BLI_CMD_SYSTEM_RESET] ||
                             i_avs_writedata[`BLI_CMD_SYSTEM_RESET_LDR]);
            if (wr_take && reg_hit(i_avs_address, `BLI_REG_COMMAND) &&
                i_avs_writedata[`BLI_CMD_SYSTEM_RESET_LDR]) begin
                soft_entry_q <= 1'b1;
            end else if (state_q == ST_DECIDE) begin
                soft_entry_q <= 1'b0;
            end
        end
    end

    // boot inputs are sampled once, in the boot state
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_q   <= 1'b0;
            blank_q <= 1'b0;
        end else if (state_q == ST_BOOT) begin
            pin_q   <= i_loader_request_pin;
            blank_q <= blank_word(i_reset_vector) &&
                       blank_word(i_stack_pointer);
        end
    end

    always @* begin
        state_d      = state_q;
        cause_d      = cause_q;
        unlock_clear = 1'b0;
        case (state_q)
            ST_HOLD: begin
                unlock_clear = 1'b1;
                if (i_external_reset_n) begin
                    state_d = ST_BOOT;
                end
            end
            ST_BOOT: begin
                state_d = ST_DECIDE;
            end
            ST_DECIDE: begin
                // disable outranks soft entry, then blank, then the pin
                if (!cfg_q[`BLI_CFG_LOADER_EN]) begin
                    cause_d = `BLI_CAUSE_NONE;
                    state_d = ST_APP;
                end else if (soft_entry_q) begin
                    cause_d = `BLI_CAUSE_SOFT;
                    state_d = ST_LOADER;
                end else if (blank_q) begin
                    cause_d = `BLI_CAUSE_BLANK;
                    state_d = ST_LOADER;
                end else if (!cfg_q[`BLI_CFG_FAST_BOOT] &&
                             pin_q == cfg_q[`BLI_CFG_INVOKE_LVL]) begin
                    cause_d = `BLI_CAUSE_PIN;
                    state_d = ST_LOADER;
                end else begin
                    cause_d = `BLI_CAUSE_NONE;
                    state_d = ST_APP;
                end
            end
            ST_LOADER: begin
                state_d = ST_LOADER;
            end
            ST_APP: begin
                state_d = ST_APP;
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
        // external reset pulse or system reset restarts the boot
        if (!i_external_reset_n) begin
            state_d      = ST_HOLD;
            unlock_clear = 1'b1;
        end else if (soft_reset_q) begin
            state_d      = ST_BOOT;
            unlock_clear = 1'b1;
        end
    end

    // start pulses stand one cycle; active follows the next state
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q         <= ST_BOOT;
            cause_q         <= `BLI_CAUSE_NONE;
            o_loader_start  <= 1'b0;
            o_loader_active <= 1'b0;
            o_app_start     <= 1'b0;
            o_app_vector    <= {`BLI_DATA_W{1'b0}};
        end else begin
            state_q         <= state_d;
            cause_q         <= cause_d;
            o_loader_start  <= (state_q == ST_DECIDE) &&
                               (state_d == ST_LOADER);
            o_loader_active <= (state_d == ST_LOADER);
            o_app_start     <= (state_q == ST_DECIDE) &&
                               (state_d == ST_APP);
            if (state_q == ST_DECIDE && state_d == ST_APP) begin
                o_app_vector <= i_reset_vector;
            end
        end
    end

    // password words only count while the loader runs
    // a failed compare leaves the fail flag up; the host may retry
    bli_pw_check u_pw (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_clear    (unlock_clear),
        .i_wr       (pw_wr && in_loader),
        .i_idx      (i_avs_address[2:0]),
        .i_word     (i_avs_writedata),
        .i_secret   (i_user_password),
        .o_unlocked (unlocked),
        .o_fail     (pw_fail)
    );

    assign o_loader_access_granted = unlocked;

    // pins follow the registered active flag, one cycle behind
    bli_link_gate u_link (
        .i_clk_sys              (i_clk_sys),
        .i_rst_n                (i_rst_n),
        .i_enable               (o_loader_active),
        .i_loader_uart_rx       (i_loader_uart_rx),
        .o_loader_uart_tx       (o_loader_uart_tx),
        .i_loader_i2c_clock     (i_loader_i2c_clock),
        .o_loader_i2c_clock_out (o_loader_i2c_clock_out),
        .o_loader_i2c_clock_oe  (o_loader_i2c_clock_oe),
        .i_loader_i2c_data      (i_loader_i2c_data),
        .o_loader_i2c_data_out  (o_loader_i2c_data_out),
        .o_loader_i2c_data_oe   (o_loader_i2c_data_oe),
        .i_core_tx              (i_core_tx),
        .i_core_i2c_clock_low   (i_core_i2c_clock_low),
        .i_core_i2c_data_low    (i_core_i2c_data_low),
        .o_core_rx              (o_core_rx),
        .o_core_i2c_clock       (o_core_i2c_clock),
        .o_core_i2c_data        (o_core_i2c_data)
    );

endmodule
`default_nettype wire

// ==== bli_invoke_monitor.sv ====
// assertion checker for the boot loader invoke logic
`timescale 1ns/1ps
`default_nettype none
`include "bli_consts.vh"
module bli_invoke_monitor (
    input wire logic                   i_clk_sys,
    input wire logic                   i_rst_n,
    input wire logic                   i_avs_read,
    input wire logic                   i_avs_write,
    input wire logic                   o_avs_waitrequest,
    input wire logic                   i_external_reset_n,
    input wire logic [`BLI_DATA_W-1:0] i_reset_vector,
    input wire logic                   o_loader_start,
    input wire logic                   o_loader_active,
    input wire logic                   o_app_start,
    input wire logic [`BLI_DATA_W-1:0] o_app_vector,
    input wire logic                   o_loader_access_granted,
    input wire logic                   i_loader_uart_rx,
    input wire logic                   o_loader_uart_tx,
    input wire logic                   o_loader_i2c_clock_out,
    input wire logic                   o_loader_i2c_clock_oe,
    input wire logic                   o_loader_i2c_data_out,
    input wire logic                   o_loader_i2c_data_oe,
    input wire logic                   i_core_tx,
    input wire logic                   o_core_rx
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence req_pending;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence answer_one;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    // link flops lag the enable, so two settled cycles are required
    sequence link_on;
        o_loader_active && $past(o_loader_active) && $past(o_loader_active, 2);
    endsequence
    bus_answer_a: assert property (req_pending |=> answer_one)
        else $error("bus request not answered in one cycle");
    start_pulse_a: assert property (o_loader_start |=> !o_loader_start)
        else $error("loader start longer than one cycle");
    active_set_a: assert property (o_loader_start |-> ##[0:1] o_loader_active)
        else $error("loader start without active level");
    app_vector_a: assert property (o_app_start |-> !o_loader_start ##[0:1]
        (o_app_vector == i_reset_vector))
        else $error("app start with wrong vector or with loader");
    link_idle_a: assert property (!o_loader_active && !$past(o_loader_active)
        && !$past(o_loader_active, 2) |-> o_loader_uart_tx
        && !o_loader_i2c_clock_oe && !o_loader_i2c_data_oe)
        else $error("link pins driven while loader idle");
    tx_follow_a: assert property (link_on |->
        o_loader_uart_tx == $past(i_core_tx))
        else $error("uart tx does not follow core");
    rx_follow_a: assert property (link_on |->
        o_core_rx == $past(i_loader_uart_rx))
        else $error("core rx does not follow pin");
    open_drain_a: assert property (!o_loader_i2c_clock_out
        && !o_loader_i2c_data_out)
        else $error("open drain output drives high");
    pw_clear_a: assert property (!i_external_reset_n |-> ##[1:3]
        !o_loader_access_granted)
        else $error("access kept across boot reset");
endmodule
bind bli_invoke bli_invoke_monitor u_mon (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .i_external_reset_n(i_external_reset_n),
    .i_reset_vector(i_reset_vector), .o_loader_start(o_loader_start),
    .o_loader_active(o_loader_active), .o_app_start(o_app_start),
    .o_app_vector(o_app_vector),
    .o_loader_access_granted(o_loader_access_granted),
    .i_loader_uart_rx(i_loader_uart_rx), .o_loader_uart_tx(o_loader_uart_tx),
    .o_loader_i2c_clock_out(o_loader_i2c_clock_out),
    .o_loader_i2c_clock_oe(o_loader_i2c_clock_oe),
    .o_loader_i2c_data_out(o_loader_i2c_data_out),
    .o_loader_i2c_data_oe(o_loader_i2c_data_oe),
    .i_core_tx(i_core_tx), .o_core_rx(o_core_rx));
`default_nettype wire

// ==== bli_host_model.sv ====
// programming host model on the loader pins
`timescale 1ns/1ps
`default_nettype none
module bli_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_scl_oe,
    input  wire logic i_sda_oe,
    output logic      o_external_reset_n,
    output logic      o_loader_request_pin,
    output logic      o_uart_rx,
    output wire logic o_scl,
    output wire logic o_sda
);
    logic sda_oe_q = 1'b0;
    // pull-ups: a released line reads high
    assign o_scl = ~i_scl_oe;
    assign o_sda = ~(i_sda_oe | sda_oe_q);
    initial begin
        o_external_reset_n = 1'b1;
        o_loader_request_pin = 1'b0;
        o_uart_rx = 1'b1;
    end
    task automatic set_pin(input logic v);
        @(posedge i_clk_sys);
        o_loader_request_pin <= v;
    endtask
    // the pin stays put through the reboot check
    task automatic pulse_reset();
        @(posedge i_clk_sys);
        o_external_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        o_external_reset_n <= 1'b1;
    endtask
    task automatic drive(input logic rx, input logic sda_low);
        @(posedge i_clk_sys);
        o_uart_rx <= rx;
        sda_oe_q <= sda_low;
    endtask
endmodule
`default_nettype wire

// ==== tb_bli_invoke.sv ====
// self-checking bench for the boot loader invoke logic
`timescale 1ns/1ps
`default_nettype none
`include "bli_consts.vh"
module tb_bli_invoke;
    logic         i_clk_sys, i_rst_n, avs_read, avs_write;
    logic         core_tx, core_scl_low, core_sda_low;
    logic [3:0]   avs_address;
    logic [31:0]  avs_writedata, reset_vector, stack_pointer, q;
    logic [255:0] user_password;
    wire  [31:0]  avs_readdata, app_vector;
    wire          waitreq, ext_rst_n, req_pin, uart_rx, uart_tx, scl, sda;
    wire          scl_oe, sda_oe, ld_start, ld_active, app_start, granted;
    wire          core_rx, core_scl, core_sda;
    int           n_fail = 0;
    int           n_checks = 0;
    int           k;
    logic [2:0]   cfg_t [6] = '{3'h7, 3'h1, 3'h3, 3'h3, 3'h3, 3'h0};
    logic [1:0]   cmd_t [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1};
    logic [1:0]   cause_t [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    logic [5:0]   pin_t = 6'b000001;
    logic [5:0]   blank_t = 6'b100100;
    logic [5:0]   ldr_t = 6'b001110;
    bli_invoke u_dut (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(waitreq),
        .i_external_reset_n(ext_rst_n), .i_loader_request_pin(req_pin),
        .i_reset_vector(reset_vector), .i_stack_pointer(stack_pointer),
        .i_user_password(user_password), .o_loader_start(ld_start),
        .o_loader_active(ld_active), .o_app_start(app_start),
        .o_app_vector(app_vector), .o_loader_access_granted(granted),
        .i_loader_uart_rx(uart_rx), .o_loader_uart_tx(uart_tx),
        .i_loader_i2c_clock(scl), .o_loader_i2c_clock_out(),
        .o_loader_i2c_clock_oe(scl_oe), .i_loader_i2c_data(sda),
        .o_loader_i2c_data_out(), .o_loader_i2c_data_oe(sda_oe),
        .i_core_tx(core_tx), .i_core_i2c_clock_low(core_scl_low),
        .i_core_i2c_data_low(core_sda_low), .o_core_rx(core_rx),
        .o_core_i2c_clock(core_scl), .o_core_i2c_data(core_sda));
    bli_host_model u_host (
        .i_clk_sys(i_clk_sys), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe),
        .o_external_reset_n(ext_rst_n), .o_loader_request_pin(req_pin),
        .o_uart_rx(uart_rx), .o_scl(scl), .o_sda(sda));
    task automatic conclude();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one avalon transfer; the request stands until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge i_clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_fail++;
            conclude();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    // start pulses stand one cycle, so look at every falling edge
    task automatic boot_wait(input logic exp_ld);
        int n;
        logic [1:0] got;
        got = 2'b00;
        for (n = 0; n < 16 && got == 2'b00; n++) begin
            @(negedge i_clk_sys);
            got = {app_start === 1'b1, ld_start === 1'b1};
        end
        chk({30'h0, got}, exp_ld ? 32'h1 : 32'h2);
    endtask
    task automatic link_chk(input logic [5:0] e);
        repeat (3) @(negedge i_clk_sys);
        chk({26'h0, uart_tx, core_rx, scl, core_scl, sda, core_sda}, {26'h0, e});
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
    initial begin
        i_rst_n = 1'b0;
        {avs_read, avs_write, core_tx, core_scl_low, core_sda_low} = 5'h04;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        reset_vector = 32'h0000_4001;
        stack_pointer = 32'h2000_1000;
        for (k = 0; k < 8; k++)
            user_password[32*k +: 32] = 32'h5a5a_0100 + k;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        boot_wait(1'b0);
        chk(app_vector, 32'h0000_4001);
        rd_chk(`BLI_REG_CONFIG, 32'h7, {29'h0, `BLI_CFG_RESET});
        rd_chk(4'h5, 32'hffff_ffff, 32'h0);
        rd_chk(`BLI_REG_COMMAND, 32'hffff_ffff, 32'h0);
        rd_chk(`BLI_REG_STATUS, 32'h307, 32'h2);
        u_host.set_pin(1'b1);
        u_host.pulse_reset();
        boot_wait(1'b1);
        rd_chk(`BLI_REG_STATUS, 32'h307, 32'h101);
        @(posedge i_clk_sys);
        core_tx <= 1'b0;
        core_scl_low <= 1'b1;
        u_host.drive(1'b0, 1'b1);
        link_chk(6'h00);
        @(posedge i_clk_sys);
        {core_tx, core_scl_low, core_sda_low} <= 3'b101;
        u_host.drive(1'b1, 1'b0);
        link_chk(6'h3c);
        for (k = 0; k < 8; k++)
            bus(1'b1, 4'h8 + k[3:0], user_password[32*k +: 32] ^ (k == 7));
        rd_chk(`BLI_REG_STATUS, 32'h24, 32'h20);
        chk({31'h0, granted}, 32'h0);
        for (k = 0; k < 8; k++)
            bus(1'b1, 4'h8 + k[3:0], user_password[32*k +: 32]);
        rd_chk(`BLI_REG_STATUS, 32'h24, 32'h04);
        chk({31'h0, granted}, 32'h1);
        for (k = 0; k < 6; k++) begin
            bus(1'b1, `BLI_REG_CONFIG, {29'h0, cfg_t[k]});
            reset_vector <= blank_t[k] ? `BLI_BLANK_WORD : 32'h0000_4001;
            stack_pointer <= blank_t[k] ? `BLI_BLANK_WORD : 32'h2000_1000;
            u_host.set_pin(pin_t[k]);
            if (cmd_t[k] != 2'h0)
                bus(1'b1, `BLI_REG_COMMAND, {30'h0, cmd_t[k]});
            else
                u_host.pulse_reset();
            boot_wait(ldr_t[k]);
            rd_chk(`BLI_REG_STATUS, 32'h303, ldr_t[k] ?
                   {22'h0, cause_t[k], 8'h01} : 32'h2);
        end
        conclude();
    end
endmodule
`default_nettype wire
